// >>> rtl/sense_pkg.sv
// Constants, layouts and states for the channel sense status reporter.
// Assumes a single system clock and a synchronous active-high reset.
package sense_pkg;

  // ----------------------------------------
  // Channel command codes and fixed byte values
  // ----------------------------------------
  localparam logic [7:0] CMD_SENSE     = 8'h04;
  localparam logic [7:0] CMD_SENSE_ID  = 8'he4;
  localparam logic [7:0] CMD_SET_MASK  = 8'h11;
  localparam logic [7:0] CMD_READ_MASK = 8'h14;
  localparam logic [7:0] ID_LEAD_BYTE  = 8'hff;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;

  // ----------------------------------------
  // Transfer lengths in bytes
  // ----------------------------------------
  localparam logic [4:0] SENSE_LEN = 5'h10;
  localparam logic [4:0] ID_LEN    = 5'h07;
  localparam logic [4:0] MASK_LEN  = 5'h04;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Unit check mask codes
  // ----------------------------------------
  localparam logic [1:0] UC_NONE = 2'h0;
  localparam logic [1:0] UC_END  = 2'h1;
  localparam int         UC_CONDS = 16;

  // ----------------------------------------
  // Sense byte layouts, first field is bit 0 (msb)
  // ----------------------------------------
  typedef struct packed {
    logic command_rejected_flag;
    logic intervention;
    logic outbound_parity_error_flag;
    logic equipment_fault_flag;
    logic data_error_flag;
    logic overrun;
    logic control_word_rejected_flag;
    logic bounds_violation_flag;
  } sense_flags_t;

  typedef struct packed {
    logic busy_as_retry_switch;
    logic async_posting_switch;
    logic reserved;
    logic stream_switch;
    logic wide_bus_switch;
    logic fast_transfer_switch;
    logic [1:0] addr_count_code;
  } mode_switch_t;

  localparam sense_flags_t FLAGS_RESET = '0;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_LOAD = 3'b100
  } seq_state_t;

endpackage

// >>> rtl/unit_check_decoder.sv
// Unit check decision from the two-bit-per-condition mask.
// Assumes condition strobes are one-cycle pulses on clk_sys_i.
`timescale 1ns/1ps
module unit_check_decoder (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  input  wire logic [31:0]                   mask_i,
  input  wire logic [sense_pkg::UC_CONDS-1:0] cond_i,
  input  wire logic                          ddb_done_i,
  output logic                               immediate_o,
  output logic                               end_check_o
);
  import sense_pkg::*;

  logic [UC_CONDS-1:0] imm_hit;
  logic [UC_CONDS-1:0] end_hit;
  logic                pending;

  // Condition k owns mask bits 2k and 2k+1, counted from the msb
  function automatic logic [1:0] cond_code(input logic [31:0] m, input int k);
    cond_code = m[31-2*k -: 2];
  endfunction

  // ----------------------------------------
  // Per-condition decode
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < UC_CONDS; gi++)
    begin : g_cond
      // RL20: code to reporting action
      assign imm_hit[gi] = cond_i[gi] && (cond_code(mask_i, gi) > UC_END);
      assign end_hit[gi] = cond_i[gi] && (cond_code(mask_i, gi) == UC_END);
    end
  endgenerate

  // RL20: deferred check held until descriptor completes
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      pending <= 1'b0;
    else if (|end_hit)
      pending <= 1'b1;
    else if (ddb_done_i)
      pending <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      immediate_o <= 1'b0;
      end_check_o <= 1'b0;
    end
    else
    begin
      immediate_o <= |imm_hit;
      end_check_o <= ddb_done_i && (pending || (|end_hit));
    end
  end

  chk_immediate_code: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL20
    (|imm_hit) |=> immediate_o) else $error("immediate unit check missed");

endmodule // unit_check_decoder

// >>> rtl/sense_status_reporter.sv
// Sense, identification and unit check mask service for the channel interface.
// Assumes byte handshakes and event strobes synchronous to clk_sys_i.
//
// Function
// RL1: Command reject flag on bad command or sequence
// RL2: Intervention and overrun bits always zero
// RL3: Parity error sets outbound parity flag
// RL4: Malfunction sets equipment fault flag
// RL5: Non-parity data error sets data flag
// RL6: Control word errors, late sequence errors
// RL7: Protect violation or oversize descriptor sets bounds
// RL8: Assigned bit from current user state
// RL9: Descriptor-in-progress bit while processing
// RL10: Transfer-wait bit when any wait outstanding
// RL11: Active user identifier in bits 3-7
// RL12: Address switches A and B in byte 2
// RL13: Mode bit 0; busy reported as retry
// RL14: Task completion posted at next command
// RL15: Feature switches gated by channel support
// RL16: Address count code 1, 8, 16, 32
// RL17: Reserved byte, last address, control word
// RL18: Seven identification bytes, first is FF
// RL19: Revision and feature bytes in identification
// RL20: Two-bit code decides unit check action
// RL21: Mask is 32 bits, three condition groups
// RL22: Mask loaded by 11, returned by 14
// RL23: Sense command 04 returns sixteen bytes
`timescale 1ns/1ps
module sense_status_reporter #(
  parameter logic [15:0] CU_TYPE       = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEV_TYPE      = 16'h5678, // Arbitrary value
  parameter logic [7:0]  FW_REVISION   = 8'h01,
  parameter logic [7:0]  FEATURES      = 8'h00
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  input  wire logic                    cmd_valid_i,
  input  wire logic [7:0]              cmd_code_i,
  output logic                         cmd_busy_o,
  output logic                         tx_valid_o,
  output logic [7:0]                   tx_data_o,
  input  wire logic                    tx_ready_i,
  input  wire logic                    rx_valid_i,
  input  wire logic [7:0]              rx_data_i,
  output logic                         rx_ready_o,
  input  wire logic                    reject_evt_i,
  input  wire logic                    parity_evt_i,
  input  wire logic                    equip_evt_i,
  input  wire logic                    data_evt_i,
  input  wire logic                    ctl_word_err_i,
  input  wire logic                    seq_err_evt_i,
  input  wire logic                    bytes_moved_i,
  input  wire logic                    memory_protect_violation_i,
  input  wire logic                    ddb_oversize_i,
  input  wire logic                    processor_assigned_flag_i,
  input  wire logic                    data_descriptor_block_i,
  input  wire logic [7:0]              transfer_wait_condition_i,
  input  wire logic [4:0]              current_user_id_i,
  input  wire logic [3:0]              addr_switch_a_i,
  input  wire logic [3:0]              addr_switch_b_i,
  input  wire sense_pkg::mode_switch_t mode_switch_i,
  input  wire logic [23:0]             last_mem_addr_i,
  input  wire logic [63:0]             host_control_status_word_i,
  input  wire logic                    processor_busy_i,
  output logic                         busy_o,
  output logic                         retry_o,
  input  wire logic                    task_done_event_i,
  output logic                         post_task_done_o,
  input  wire logic [2:0]              channel_caps_i,
  output logic                         use_stream_o,
  output logic                         use_wide_bus_o,
  output logic                         use_fast_xfer_o,
  output logic [5:0]                   unit_addr_count_o,
  input  wire logic [7:0]              formatter_cond_i,
  input  wire logic [4:0]              multiply_processor_conditions_i,
  input  wire logic                    channel_processor_cond_i,
  input  wire logic                    attached_processor_reject_i,
  input  wire logic                    ddb_done_i,
  output logic                         unit_check_now_o,
  output logic                         abort_ddb_o,
  output logic                         unit_check_end_o,
  output sense_pkg::sense_flags_t      sense_flags_o
);
  import sense_pkg::*;

  seq_state_t   state;
  logic [7:0]   cur_cmd;
  logic [4:0]   idx;
  logic [4:0]   cur_len;
  logic [7:0]   sel_cmd;
  logic [4:0]   sel_idx;
  logic [7:0]   sel_byte;
  logic [31:0]  mask;
  logic [23:0]  mask_stage;
  logic         tx_fire;
  logic         last_beat;
  logic         sense_done;
  logic         task_pending;
  sense_flags_t flags;
  sense_flags_t flag_set;
  sense_flags_t next_flags;
  logic [UC_CONDS-1:0] conds;

  function automatic logic [4:0] cmd_len(input logic [7:0] code);
    unique case (code)
      CMD_SENSE:     cmd_len = SENSE_LEN;
      CMD_SENSE_ID:  cmd_len = ID_LEN;
      CMD_SET_MASK:  cmd_len = MASK_LEN;
      CMD_READ_MASK: cmd_len = MASK_LEN;
      default:       cmd_len = 5'h00;
    endcase
  endfunction

  function automatic logic [5:0] addr_count(input logic [1:0] code);
    unique case (code)
      2'h0: addr_count = 6'h01;
      2'h1: addr_count = 6'h08;
      2'h2: addr_count = 6'h10;
      2'h3: addr_count = 6'h20;
    endcase
  endfunction

  // ----------------------------------------
  // Sticky error flags
  // ----------------------------------------
  always_comb
  begin
    flag_set = '0;
    // RL1: rejected command, or a command while busy
    flag_set.command_rejected_flag = reject_evt_i || (cmd_valid_i && state != ST_IDLE);
    // RL3: interface parity
    flag_set.outbound_parity_error_flag = parity_evt_i;
    // RL4: malfunction, detail travels in the control word
    flag_set.equipment_fault_flag = equip_evt_i;
    // RL5: data error without parity
    flag_set.data_error_flag = data_evt_i;
    // RL6: control word error or late sequence error
    flag_set.control_word_rejected_flag = ctl_word_err_i || (seq_err_evt_i && bytes_moved_i);
    // RL7: bounds problems
    flag_set.bounds_violation_flag = memory_protect_violation_i || ddb_oversize_i;
    // RL2: never raised
    flag_set.intervention = 1'b0;
    flag_set.overrun      = 1'b0;
    // Set wins, so an event on the closing beat of a sense survives
    next_flags = sense_done ? flag_set : (flags | flag_set);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      flags <= FLAGS_RESET;
    else
      flags <= next_flags;
  end

  assign sense_flags_o = flags;

  // ----------------------------------------
  // Outgoing byte selection
  // ----------------------------------------
  assign sel_cmd = (state == ST_IDLE) ? cmd_code_i : cur_cmd;
  assign sel_idx = (state == ST_IDLE) ? 5'h00 : idx + 5'h01;

  always_comb
  begin
    sel_byte = RESERVED_BYTE;
    if (sel_cmd == CMD_SENSE)
    begin
      // RL23: sixteen sense bytes
      unique case (sel_idx)
        5'h00: sel_byte = flags;
        // RL8: RL9: RL10: RL11: byte 1 state and user
        5'h01: sel_byte = {processor_assigned_flag_i, data_descriptor_block_i,
                           |transfer_wait_condition_i, current_user_id_i};
        // RL12: switch A in high nibble
        5'h02: sel_byte = {addr_switch_a_i, addr_switch_b_i};
        // RL13: RL14: RL15: RL16: switch image
        5'h03: sel_byte = mode_switch_i;
        // RL17: reserved, address, control word
        5'h04: sel_byte = RESERVED_BYTE;
        5'h05: sel_byte = last_mem_addr_i[23:16];
        5'h06: sel_byte = last_mem_addr_i[15:8];
        5'h07: sel_byte = last_mem_addr_i[7:0];
        default: sel_byte = host_control_status_word_i[8'(63 - 8*(sel_idx - 5'h08)) -: 8];
      endcase
    end
    else if (sel_cmd == CMD_SENSE_ID)
    begin
      // RL18: RL19: identification bytes
      unique case (sel_idx)
        5'h00: sel_byte = ID_LEAD_BYTE;
        5'h01: sel_byte = CU_TYPE[15:8];
        5'h02: sel_byte = CU_TYPE[7:0];
        5'h03: sel_byte = FW_REVISION;
        5'h04: sel_byte = DEV_TYPE[15:8];
        5'h05: sel_byte = DEV_TYPE[7:0];
        default: sel_byte = FEATURES;
      endcase
    end
    else if (sel_cmd == CMD_READ_MASK)
    begin
      // RL22: mask returned unaltered, first byte first
      sel_byte = mask[8'(31 - 8*sel_idx) -: 8];
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  assign tx_fire    = tx_valid_o && tx_ready_i;
  assign last_beat  = (idx == cur_len - 5'h01);
  assign sense_done = (state == ST_SEND) && tx_fire && last_beat && (cur_cmd == CMD_SENSE);
  assign cmd_busy_o = (state != ST_IDLE);
  assign rx_ready_o = (state == ST_LOAD);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state      <= ST_IDLE;
      cur_cmd    <= 8'h00;
      cur_len    <= 5'h00;
      idx        <= 5'h00;
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          idx <= 5'h00;
          if (cmd_valid_i && cmd_len(cmd_code_i) != 5'h00)
          begin
            cur_cmd <= cmd_code_i;
            cur_len <= cmd_len(cmd_code_i);
            if (cmd_code_i == CMD_SET_MASK)
              state <= ST_LOAD;
            else
            begin
              state      <= ST_SEND;
              tx_valid_o <= 1'b1;
              tx_data_o  <= sel_byte;
            end
          end
        end
        ST_SEND:
        begin
          if (tx_fire)
          begin
            if (last_beat)
            begin
              state      <= ST_IDLE;
              tx_valid_o <= 1'b0;
            end
            else
            begin
              idx       <= sel_idx;
              tx_data_o <= sel_byte;
            end
          end
        end
        ST_LOAD:
        begin
          if (rx_valid_i)
          begin
            idx <= idx + 5'h01;
            if (last_beat)
              state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Unit check mask
  // ----------------------------------------
  // RL22: whole mask committed on the fourth byte only
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      mask       <= MASK_RESET;
      mask_stage <= 24'h000000;
    end
    else if (state == ST_LOAD && rx_valid_i)
    begin
      mask_stage <= {mask_stage[15:0], rx_data_i};
      if (last_beat)
        mask <= {mask_stage, rx_data_i};
    end
  end

  // RL21: formatter, multiply processor, channel processor groups
  assign conds = {memory_protect_violation_i, attached_processor_reject_i, channel_processor_cond_i,
                  multiply_processor_conditions_i, formatter_cond_i};

  unit_check_decoder u_decoder (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .mask_i     (mask),
    .cond_i     (conds),
    .ddb_done_i (ddb_done_i),
    .immediate_o(unit_check_now_o),
    .end_check_o(unit_check_end_o)
  );

  // RL20: immediate check aborts the descriptor
  assign abort_ddb_o = unit_check_now_o;

  // ----------------------------------------
  // Mode switch effects
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      busy_o            <= 1'b0;
      retry_o           <= 1'b0;
      use_stream_o      <= 1'b0;
      use_wide_bus_o    <= 1'b0;
      use_fast_xfer_o   <= 1'b0;
      unit_addr_count_o <= 6'h01;
    end
    else
    begin
      // RL13: busy turned into retry when switched
      busy_o  <= processor_busy_i && !mode_switch_i.busy_as_retry_switch;
      retry_o <= processor_busy_i && mode_switch_i.busy_as_retry_switch;
      // RL15: feature only if enabled and supported
      use_stream_o    <= mode_switch_i.stream_switch && channel_caps_i[0];
      use_wide_bus_o  <= mode_switch_i.wide_bus_switch && channel_caps_i[1];
      use_fast_xfer_o <= mode_switch_i.fast_transfer_switch && channel_caps_i[2];
      // RL16: count decoded from two switch bits
      unit_addr_count_o <= addr_count(mode_switch_i.addr_count_code);
    end
  end

  // RL14: posting waits for the next command unless async is on; async may be lost
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      task_pending     <= 1'b0;
      post_task_done_o <= 1'b0;
    end
    else
    begin
      post_task_done_o <= mode_switch_i.async_posting_switch ? task_done_event_i
                                                             : (cmd_valid_i && task_pending);
      if (task_done_event_i && !mode_switch_i.async_posting_switch)
        task_pending <= 1'b1;
      else if (cmd_valid_i || mode_switch_i.async_posting_switch)
        task_pending <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_reject_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL1
    reject_evt_i |=> flags.command_rejected_flag) else $error("reject flag not set");
  chk_unused_bits: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL2
    !flags.intervention && !flags.overrun) else $error("unused sense bit set");
  chk_parity_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL3
    parity_evt_i |=> flags.outbound_parity_error_flag) else $error("parity flag not set");
  chk_equip_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL4
    equip_evt_i |=> flags.equipment_fault_flag) else $error("equipment flag not set");
  chk_data_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL5
    data_evt_i |=> flags.data_error_flag) else $error("data flag not set");
  chk_late_seq_error: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL6
    seq_err_evt_i && bytes_moved_i |=> flags.control_word_rejected_flag) else $error("late sequence error lost");
  chk_bounds_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL7
    ddb_oversize_i |=> flags.bounds_violation_flag) else $error("bounds flag not set");
  chk_id_lead: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL18
    state == ST_IDLE && cmd_valid_i && cmd_code_i == CMD_SENSE_ID |=> tx_valid_o && tx_data_o == ID_LEAD_BYTE)
    else $error("identification lead byte wrong");
  chk_mask_stable: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL22
    state != ST_LOAD |=> $stable(mask)) else $error("mask changed outside load");
  chk_retry_route: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL13
    processor_busy_i && mode_switch_i.busy_as_retry_switch |=> retry_o && !busy_o) else $error("busy not retry");
  chk_posting_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL14
    !mode_switch_i.async_posting_switch && !cmd_valid_i |=> !post_task_done_o) else $error("posted without command");
  chk_sense_len: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL23
    state == ST_SEND && cur_cmd == CMD_SENSE |-> cur_len == SENSE_LEN) else $error("sense length wrong");

  cov_sense_done: cover property (@(posedge clk_sys_i) disable iff (rst_i) sense_done);
  cov_mask_load: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state == ST_LOAD ##1 state == ST_IDLE);
  cov_immediate: cover property (@(posedge clk_sys_i) disable iff (rst_i) unit_check_now_o);
  cov_end_check: cover property (@(posedge clk_sys_i) disable iff (rst_i) unit_check_end_o);

endmodule // sense_status_reporter

// >>> test/host_channel_model.sv
// Host channel model: collects sent bytes, feeds mask bytes on request.
// Assumes byte handshakes on clk_sys_i; slow_i halves the acceptance rate.
`timescale 1ns/1ps
module host_channel_model (
  input  wire logic        clk_sys_i,
  input  wire logic        slow_i,
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        rx_ready_i,
  input  wire logic [31:0] load_word_i,
  output logic             tx_ready_o,
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o
);
  logic [7:0] got [$];
  logic [1:0] idx = 2'h0;
  logic       ph  = 1'h0;
  always @(posedge clk_sys_i)
  begin
    ph <= ~ph;
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
  end
  always @(posedge clk_sys_i)
  begin
    if (!rx_ready_i)
      idx <= 2'h0;
    else
      idx <= idx + 2'h1;
  end
  assign tx_ready_o = !slow_i || ph;
  assign rx_valid_o = rx_ready_i;
  // Idle data inverted so a stale byte never passes
  assign rx_data_o  = rx_ready_i ? load_word_i[8*(3-idx) +: 8] : ~load_word_i[7:0];
endmodule // host_channel_model

// >>> test/sense_status_reporter_tb.sv
// Random and corner-case bench for the sense status reporter.
// Assumes the host channel model is compiled first.
`timescale 1ns/1ps
module sense_status_reporter_tb;
  import sense_pkg::*;
  localparam logic [15:0] CU = 16'h3a5c; // Arbitrary value
  localparam logic [15:0] DT = 16'h6d21; // Arbitrary value
  localparam logic [7:0]  FW = 8'h07;
  logic clk_sys_i = '0, rst_i = '1, cmd_valid_i = '0, tx_ready_i, rx_valid_i, slow = '0, posted;
  logic reject_evt_i = '0, parity_evt_i = '0, equip_evt_i = '0, data_evt_i = '0, ctl_word_err_i = '0;
  logic seq_err_evt_i = '0, bytes_moved_i = '0, memory_protect_violation_i = '0, ddb_oversize_i = '0;
  logic processor_assigned_flag_i = '0, data_descriptor_block_i = '0, processor_busy_i = '0;
  logic task_done_event_i = '0, channel_processor_cond_i = '0, attached_processor_reject_i = '0, ddb_done_i = '0;
  logic [7:0] cmd_code_i = '0, rx_data_i, transfer_wait_condition_i = '0, formatter_cond_i = '0, f, tx_data_o;
  logic [4:0] current_user_id_i = '0, multiply_processor_conditions_i = '0;
  logic [3:0] addr_switch_a_i = '0, addr_switch_b_i = '0;
  logic [2:0] channel_caps_i = '0;
  logic [23:0] last_mem_addr_i = '0;
  logic [63:0] host_control_status_word_i = '0;
  logic [31:0] mw = '0;
  logic [15:0] lf = 16'h001a;
  logic [5:0] unit_addr_count_o;
  logic cmd_busy_o, tx_valid_o, rx_ready_o, busy_o, retry_o, post_task_done_o, use_stream_o, use_wide_bus_o;
  logic use_fast_xfer_o, unit_check_now_o, abort_ddb_o, unit_check_end_o;
  mode_switch_t mode_switch_i = '0;
  sense_flags_t sense_flags_o;
  int failures = 0, total_checks = 0, cyc = 0;

  sense_status_reporter #(.CU_TYPE(CU), .DEV_TYPE(DT), .FW_REVISION(FW), .FEATURES(8'h00)) uut (
    .clk_sys_i, .rst_i, .cmd_valid_i, .cmd_code_i, .cmd_busy_o, .tx_valid_o, .tx_data_o, .tx_ready_i,
    .rx_valid_i, .rx_data_i, .rx_ready_o, .reject_evt_i, .parity_evt_i, .equip_evt_i, .data_evt_i,
    .ctl_word_err_i, .seq_err_evt_i, .bytes_moved_i, .memory_protect_violation_i, .ddb_oversize_i,
    .processor_assigned_flag_i, .data_descriptor_block_i, .transfer_wait_condition_i, .current_user_id_i,
    .addr_switch_a_i, .addr_switch_b_i, .mode_switch_i, .last_mem_addr_i, .host_control_status_word_i,
    .processor_busy_i, .busy_o, .retry_o, .task_done_event_i, .post_task_done_o, .channel_caps_i,
    .use_stream_o, .use_wide_bus_o, .use_fast_xfer_o, .unit_addr_count_o, .formatter_cond_i,
    .multiply_processor_conditions_i, .channel_processor_cond_i, .attached_processor_reject_i,
    .ddb_done_i, .unit_check_now_o, .abort_ddb_o, .unit_check_end_o, .sense_flags_o);
  host_channel_model host (.clk_sys_i, .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .rx_ready_i(rx_ready_o), .load_word_i(mw), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i));

  initial
    forever #20 clk_sys_i = ~clk_sys_i;

  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd(output logic [31:0] r);
    lf = nx(lf);
    r[31:16] = lf;
    lf = nx(lf);
    r[15:0] = lf;
  endtask

  function automatic logic [7:0] sb(int i);
    case (i)
      0: return f;
      1: return {processor_assigned_flag_i, data_descriptor_block_i, |transfer_wait_condition_i, current_user_id_i};
      2: return {addr_switch_a_i, addr_switch_b_i};
      3: return mode_switch_i;
      4: return 8'h00;
      5, 6, 7: return last_mem_addr_i[8*(7-i) +: 8];
      default: return host_control_status_word_i[8*(15-i) +: 8];
    endcase
  endfunction

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bounded wait; a stuck sequencer must not hang
  task automatic cmd(logic [7:0] c);
    host.got.delete();
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'h1;
    cmd_code_i  <= c;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'h0;
    @(negedge clk_sys_i);
    posted = post_task_done_o;
    chk("busy", {cmd_busy_o, rx_ready_o}, {1'h1, c == CMD_SET_MASK});
    for (int n = 0; n < 200 && cmd_busy_o !== 1'h0; n++)
      @(negedge clk_sys_i);
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    logic [31:0] r;
    logic [6:0]  e;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    @(negedge clk_sys_i);
    chk("addr_count", unit_addr_count_o, 6'h01);
    chk("flags_reset", sense_flags_o, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      rnd(r);
      @(posedge clk_sys_i);
      mode_switch_i    <= {r[7], 1'h0, r[5:2], k[1:0]};
      channel_caps_i   <= r[10:8];
      processor_busy_i <= r[11];
      repeat (2) @(negedge clk_sys_i);
      chk("addr_count", unit_addr_count_o, 6'h01 << (k == 0 ? 0 : k + 2));
      chk("retry", {retry_o, busy_o}, {r[11] & r[7], r[11] & !r[7]});
      chk("features", {use_stream_o, use_wide_bus_o, use_fast_xfer_o}, {r[4:2] & {r[8], r[9], r[10]}});
    end
    slow <= 1'h1;
    cmd(CMD_SENSE_ID);
    for (int i = 0; i < 7; i++)
      chk("id_byte", host.got[i], {8'hff, CU, FW, DT, 8'h00} >> (8 * (6 - i)) & 64'hff);
    @(posedge clk_sys_i) task_done_event_i <= 1'h1;
    @(posedge clk_sys_i) task_done_event_i <= 1'h0;
    repeat (2) @(negedge clk_sys_i);
    chk("post_early", post_task_done_o, 1'h0);
    rnd(mw);
    cmd(CMD_SET_MASK);
    chk("post", posted, 1'h1);
    cmd(CMD_READ_MASK);
    chk("mask", {host.got[0], host.got[1], host.got[2], host.got[3]}, mw);
    for (int c = 0; c < 4; c++)
    begin
      mw = {c[1:0], 30'h0};
      cmd(CMD_SET_MASK);
      @(posedge clk_sys_i);
      {formatter_cond_i, multiply_processor_conditions_i, channel_processor_cond_i, attached_processor_reject_i} <= '1;
      @(posedge clk_sys_i);
      {formatter_cond_i, multiply_processor_conditions_i, channel_processor_cond_i, attached_processor_reject_i} <= '0;
      @(negedge clk_sys_i);
      chk("check_now", {unit_check_now_o, abort_ddb_o}, {2{c[1]}});
      @(posedge clk_sys_i) ddb_done_i <= 1'h1;
      @(posedge clk_sys_i) ddb_done_i <= 1'h0;
      @(negedge clk_sys_i);
      chk("check_end", unit_check_end_o, c == 1);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_sys_i);
      rnd(r);
      host_control_status_word_i[63:32] <= r;
      rnd(r);
      host_control_status_word_i[31:0] <= r;
      last_mem_addr_i <= {r[7:0], r[31:16]};
      rnd(r);
      e = r[6:0];
      {processor_assigned_flag_i, data_descriptor_block_i, transfer_wait_condition_i} <= r[16:7];
      {current_user_id_i, addr_switch_a_i, addr_switch_b_i} <= r[29:17];
      {reject_evt_i, parity_evt_i, equip_evt_i, data_evt_i, ctl_word_err_i} <= e[6:2];
      {memory_protect_violation_i, ddb_oversize_i, seq_err_evt_i, bytes_moved_i} <= {e[1:0], 1'h1, k[0]};
      @(posedge clk_sys_i);
      {reject_evt_i, parity_evt_i, equip_evt_i, data_evt_i, ctl_word_err_i} <= '0;
      {memory_protect_violation_i, ddb_oversize_i, seq_err_evt_i} <= '0;
      f = {e[6], 1'h0, e[5], e[4], e[3], 1'h0, e[2] | k[0], e[1] | e[0]};
      @(negedge clk_sys_i);
      chk("flags", sense_flags_o, f);
      cmd(CMD_SENSE);
      chk("sense_len", host.got.size(), 16);
      for (int i = 0; i < 16; i++)
        chk("sense_byte", host.got[i], sb(i));
      chk("flags_clear", sense_flags_o, 8'h00);
    end
    tally_and_finish();
  end
endmodule // sense_status_reporter_tb
